// ---- hw/iod_pkg.sv ----
// Constants for the low I/O space decoder: operation codes, address windows,
// register offsets and field widths.
// Assumes the core presents one decoded access per enabled clock cycle.
//
// Overview of operation
// - Single-bit raise and lower act only on I/O addresses 0x00 to 0x1F and do nothing elsewhere.
// - For I/O addresses 0x00 to 0x1F one chosen bit can be tested to skip on high or on low.
// - Timer event flags clear when a one is written to their bit and a zero leaves them alone.
// - A single-bit raise or lower changes only the addressed bit and never writes back the others.
// - Short I/O read and write reach I/O addresses 0x00 to 0x3F carried in the opcode.
// - Memory read and write reach an I/O register at its I/O address plus 0x20.
// - Extended I/O at data addresses 0x60 to 0xff is reachable only by memory read and write.
package iod_pkg;

    typedef enum logic [2:0] {
        IOD_OP_NONE,
        IOD_OP_IO_READ,
        IOD_OP_IO_WRITE,
        IOD_OP_MEM_READ,
        IOD_OP_MEM_WRITE,
        IOD_OP_BIT_RAISE,
        IOD_OP_BIT_LOWER,
        IOD_OP_BIT_TEST
    } iod_op_t;

    localparam int IOD_DW = 8;
    localparam int IOD_IOAW = 6;
    localparam int IOD_MAW = 8;
    localparam int IOD_BITW = 3;

    localparam logic [IOD_IOAW-1:0] IOD_BIT_SPACE_LAST = 6'h1f;
    localparam logic [IOD_IOAW-1:0] IOD_IO_LAST = 6'h3f;
    localparam logic [IOD_MAW-1:0] IOD_MEM_IO_OFFSET = 8'h20;
    localparam logic [IOD_MAW-1:0] IOD_MEM_IO_FIRST = 8'h20;
    localparam logic [IOD_MAW-1:0] IOD_MEM_IO_LAST = 8'h5f;
    localparam logic [IOD_MAW-1:0] IOD_EXT_FIRST = 8'h60;
    localparam logic [IOD_MAW-1:0] IOD_EXT_LAST = 8'hff;

    localparam logic [IOD_IOAW-1:0] IOD_PORT_B_PIN_LEVEL = 6'h03;
    localparam logic [IOD_IOAW-1:0] IOD_PORT_B_DIRECTION = 6'h04;
    localparam logic [IOD_IOAW-1:0] IOD_PORT_B_OUTPUT = 6'h05;
    localparam logic [IOD_IOAW-1:0] IOD_PORT_C_PIN_LEVEL = 6'h06;
    localparam logic [IOD_IOAW-1:0] IOD_PORT_C_DIRECTION = 6'h07;
    localparam logic [IOD_IOAW-1:0] IOD_PORT_C_OUTPUT = 6'h08;
    localparam logic [IOD_IOAW-1:0] IOD_PORT_D_PIN_LEVEL = 6'h09;
    localparam logic [IOD_IOAW-1:0] IOD_PORT_D_DIRECTION = 6'h0a;
    localparam logic [IOD_IOAW-1:0] IOD_PORT_D_OUTPUT = 6'h0b;
    localparam logic [IOD_IOAW-1:0] IOD_PORT_A_PIN_LEVEL = 6'h0c;
    localparam logic [IOD_IOAW-1:0] IOD_PORT_A_DIRECTION = 6'h0d;
    localparam logic [IOD_IOAW-1:0] IOD_PORT_A_OUTPUT = 6'h0e;
    localparam logic [IOD_IOAW-1:0] IOD_PORT_PULLUP_BREAK_CONTROL = 6'h12;
    localparam logic [IOD_IOAW-1:0] IOD_TIMER0_EVENT_FLAGS = 6'h15;
    localparam logic [IOD_IOAW-1:0] IOD_TIMER1_EVENT_FLAGS = 6'h16;

    localparam logic [IOD_DW-1:0] IOD_PORT_A_MASK = 8'h0f;
    localparam logic [IOD_DW-1:0] IOD_TIMER0_FLAG_MASK = 8'h07;
    localparam logic [IOD_DW-1:0] IOD_TIMER1_FLAG_MASK = 8'h27;
    localparam logic [IOD_DW-1:0] IOD_RESET_VALUE = 8'h00;

endpackage

// ---- hw/iod_reg.sv ----
// One storage byte of the I/O space with ordinary or write-one-to-clear flags.
// Assumes at most one write or bit operation is presented per enabled cycle.
`timescale 1ns/1ps
module iod_reg
    import iod_pkg::*;
#(
    parameter logic [IOD_DW-1:0] MASK = 8'hff,
    parameter bit W1C = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wr,
    input wire logic [IOD_DW-1:0] wdata,
    input wire logic bit_raise,
    input wire logic bit_lower,
    input wire logic [IOD_BITW-1:0] bit_sel,
    input wire logic [IOD_DW-1:0] hw_set,
    output logic [IOD_DW-1:0] value
);
    logic [IOD_DW-1:0] value_reg;
    logic [IOD_DW-1:0] value_next;
    logic [IOD_DW-1:0] onehot;

    assign value = value_reg;

    always_comb begin
        onehot = IOD_DW'(1) << bit_sel;
        value_next = value_reg;
        if (W1C) begin
            // A flag raised by hardware in the same cycle as its clear stays set.
            if (wr) begin
                value_next = value_reg & ~wdata;
            end else if (bit_raise) begin
                value_next = value_reg & ~onehot;
            end
            value_next = (value_next | hw_set) & MASK;
        end else begin
            if (wr) begin
                value_next = wdata & MASK;
            end else if (bit_raise) begin
                value_next = (value_reg | onehot) & MASK;
            end else if (bit_lower) begin
                value_next = value_reg & ~onehot;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value_reg <= IOD_RESET_VALUE;
        end else if (ce) begin
            value_reg <= value_next;
        end
    end
endmodule

// ---- hw/iod_top.sv ----
// Low I/O space decoder with the port and timer flag registers behind it.
// Assumes the core issues one operation per enabled cycle and waits for the
// registered answer one cycle later; pin levels arrive synchronous to clk.
`timescale 1ns/1ps
module iod_top
    import iod_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire iod_op_t op,
    input wire logic [IOD_IOAW-1:0] io_addr,
    input wire logic [IOD_MAW-1:0] mem_addr,
    input wire logic [IOD_BITW-1:0] bit_sel,
    input wire logic [IOD_DW-1:0] wdata,
    input wire logic [IOD_DW-1:0] pin_a,
    input wire logic [IOD_DW-1:0] pin_b,
    input wire logic [IOD_DW-1:0] pin_c,
    input wire logic [IOD_DW-1:0] pin_d,
    input wire logic [IOD_DW-1:0] timer0_events,
    input wire logic [IOD_DW-1:0] timer1_events,
    output logic [IOD_DW-1:0] rdata,
    output logic rvalid,
    output logic skip,
    output logic ext_read,
    output logic ext_write,
    output logic [IOD_MAW-1:0] ext_addr,
    output logic [IOD_DW-1:0] ext_wdata,
    output logic [IOD_DW-1:0] port_a_drive,
    output logic [IOD_DW-1:0] port_a_enable,
    output logic [IOD_DW-1:0] port_b_drive,
    output logic [IOD_DW-1:0] port_b_enable,
    output logic [IOD_DW-1:0] port_c_drive,
    output logic [IOD_DW-1:0] port_c_enable,
    output logic [IOD_DW-1:0] port_d_drive,
    output logic [IOD_DW-1:0] port_d_enable,
    output logic [IOD_DW-1:0] pullup_break_ctrl,
    output logic [IOD_DW-1:0] timer0_flags,
    output logic [IOD_DW-1:0] timer1_flags
);
    localparam int NREG = 11;
    localparam logic [IOD_IOAW-1:0] OFFS [NREG] = '{
        IOD_PORT_B_DIRECTION, IOD_PORT_B_OUTPUT, IOD_PORT_C_DIRECTION, IOD_PORT_C_OUTPUT,
        IOD_PORT_D_DIRECTION, IOD_PORT_D_OUTPUT, IOD_PORT_A_DIRECTION, IOD_PORT_A_OUTPUT,
        IOD_PORT_PULLUP_BREAK_CONTROL, IOD_TIMER0_EVENT_FLAGS, IOD_TIMER1_EVENT_FLAGS};
    localparam logic [IOD_DW-1:0] MASKS [NREG] = '{
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, IOD_PORT_A_MASK, IOD_PORT_A_MASK,
        8'hff, IOD_TIMER0_FLAG_MASK, IOD_TIMER1_FLAG_MASK};

    // ==================================================================
    // Elaboration checks
    // ==================================================================
    // Skip polarity, bit selection and the data-space window all assume byte registers behind a fixed offset.
    if (IOD_DW != 8) begin : g_chk_dw
        $error("iod_top serves byte-wide registers only");
    end
    if (IOD_BITW != $clog2(IOD_DW)) begin : g_chk_bitw
        $error("iod_top needs a bit index that spans exactly one register");
    end
    if (IOD_MAW <= IOD_IOAW) begin : g_chk_maw
        $error("iod_top needs data addresses wider than short I/O addresses");
    end
    if (IOD_MEM_IO_OFFSET != IOD_MEM_IO_FIRST) begin : g_chk_first
        $error("iod_top needs the data-space window to start at the offset");
    end
    if (IOD_MEM_IO_LAST - IOD_MEM_IO_FIRST != IOD_MAW'(IOD_IO_LAST)) begin : g_chk_window
        $error("iod_top needs the data-space window to cover the whole short space");
    end

    // ==================================================================
    // Address decode
    // ==================================================================
    logic acc_valid;
    logic acc_write;
    logic acc_read;
    logic bit_op;
    logic ext_hit;
    logic [IOD_IOAW-1:0] acc_addr;
    logic [IOD_MAW-1:0] mem_io;

    always_comb begin
        mem_io = mem_addr - IOD_MEM_IO_OFFSET;
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_read = 1'b0;
        bit_op = 1'b0;
        ext_hit = 1'b0;
        acc_addr = io_addr;
        case (op)
            IOD_OP_IO_READ: begin
                acc_valid = (io_addr <= IOD_IO_LAST);
                acc_read = 1'b1;
            end
            IOD_OP_IO_WRITE: begin
                acc_valid = (io_addr <= IOD_IO_LAST);
                acc_write = 1'b1;
            end
            IOD_OP_MEM_READ, IOD_OP_MEM_WRITE: begin
                acc_addr = mem_io[IOD_IOAW-1:0];
                acc_valid = (mem_addr >= IOD_MEM_IO_FIRST) && (mem_addr <= IOD_MEM_IO_LAST);
                ext_hit = (mem_addr >= IOD_EXT_FIRST) && (mem_addr <= IOD_EXT_LAST);
                acc_read = (op == IOD_OP_MEM_READ);
                acc_write = (op == IOD_OP_MEM_WRITE);
            end
            IOD_OP_BIT_RAISE, IOD_OP_BIT_LOWER, IOD_OP_BIT_TEST: begin
                acc_valid = (io_addr <= IOD_BIT_SPACE_LAST);
                bit_op = 1'b1;
            end
            default: begin
                acc_valid = 1'b0;
            end
        endcase
    end

    // ==================================================================
    // Storage
    // ==================================================================
    logic [IOD_DW-1:0] vals [NREG];
    logic [NREG-1:0] hit;

    for (genvar i = 0; i < NREG; i++) begin : g_reg
        logic [IOD_DW-1:0] hw_set;
        assign hit[i] = acc_valid && (acc_addr == OFFS[i]);
        assign hw_set = (i == NREG - 2) ? timer0_events : ((i == NREG - 1) ? timer1_events : IOD_RESET_VALUE);
        iod_reg #(.MASK(MASKS[i]), .W1C(i >= NREG - 2)) u_reg (
            .clk(clk),
            .rst(rst),
            .ce(ce),
            .wr(hit[i] && acc_write),
            .wdata(wdata),
            .bit_raise(hit[i] && (op == IOD_OP_BIT_RAISE)),
            .bit_lower(hit[i] && (op == IOD_OP_BIT_LOWER) && (i < NREG - 2)),
            .bit_sel(bit_sel),
            .hw_set(hw_set),
            .value(vals[i])
        );
    end

    // ==================================================================
    // Read mux and answer
    // ==================================================================
    logic [IOD_DW-1:0] read_val;
    logic [IOD_DW-1:0] rdata_reg;
    logic [IOD_DW-1:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic skip_reg;
    logic skip_next;
    logic ext_read_reg;
    logic ext_read_next;
    logic ext_write_reg;
    logic ext_write_next;
    logic [IOD_MAW-1:0] ext_addr_reg;
    logic [IOD_MAW-1:0] ext_addr_next;
    logic [IOD_DW-1:0] ext_wdata_reg;
    logic [IOD_DW-1:0] ext_wdata_next;

    always_comb begin
        read_val = IOD_RESET_VALUE;
        if (acc_valid) begin
            case (acc_addr)
                IOD_PORT_B_PIN_LEVEL: read_val = pin_b;
                IOD_PORT_C_PIN_LEVEL: read_val = pin_c;
                IOD_PORT_D_PIN_LEVEL: read_val = pin_d;
                IOD_PORT_A_PIN_LEVEL: read_val = pin_a & IOD_PORT_A_MASK;
                default: begin
                    for (int k = 0; k < NREG; k++) begin
                        if (hit[k]) begin
                            read_val = vals[k];
                        end
                    end
                end
            endcase
        end
        rdata_next = acc_read ? read_val : IOD_RESET_VALUE;
        rvalid_next = acc_read && (acc_valid || ext_hit);
        // The skip decision reports the polarity requested: bit_sel picks the bit, wdata[0] picks high.
        skip_next = (op == IOD_OP_BIT_TEST) && acc_valid && (read_val[bit_sel] == wdata[0]);
        ext_read_next = ext_hit && (op == IOD_OP_MEM_READ);
        ext_write_next = ext_hit && (op == IOD_OP_MEM_WRITE);
        // The extended side qualifies these copies with its own strobes, so they follow every enabled cycle.
        ext_addr_next = mem_addr;
        ext_wdata_next = wdata;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= IOD_RESET_VALUE;
            rvalid_reg <= 1'b0;
            skip_reg <= 1'b0;
            ext_read_reg <= 1'b0;
            ext_write_reg <= 1'b0;
            ext_addr_reg <= IOD_MAW'(IOD_RESET_VALUE);
            ext_wdata_reg <= IOD_RESET_VALUE;
        end else if (ce) begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            skip_reg <= skip_next;
            ext_read_reg <= ext_read_next;
            ext_write_reg <= ext_write_next;
            ext_addr_reg <= ext_addr_next;
            ext_wdata_reg <= ext_wdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign rvalid = rvalid_reg;
    assign skip = skip_reg;
    assign ext_read = ext_read_reg;
    assign ext_write = ext_write_reg;
    assign ext_addr = ext_addr_reg;
    assign ext_wdata = ext_wdata_reg;

    // Register outputs are the storage flops themselves, so they follow writes one cycle later.
    assign port_b_enable = vals[0];
    assign port_b_drive = vals[1];
    assign port_c_enable = vals[2];
    assign port_c_drive = vals[3];
    assign port_d_enable = vals[4];
    assign port_d_drive = vals[5];
    assign port_a_enable = vals[6];
    assign port_a_drive = vals[7];
    assign pullup_break_ctrl = vals[8];
    assign timer0_flags = vals[9];
    assign timer1_flags = vals[10];
endmodule

// ---- verification/iod_monitor.sv ----
// Port checker for the low I/O space decoder.
// Assumes it is bound to iod_top and sees only that module's ports.
`timescale 1ns/1ps
module iod_monitor
    import iod_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire iod_op_t op,
    input wire logic [IOD_IOAW-1:0] io_addr,
    input wire logic [IOD_MAW-1:0] mem_addr,
    input wire logic [IOD_BITW-1:0] bit_sel,
    input wire logic [IOD_DW-1:0] wdata,
    input wire logic [IOD_DW-1:0] timer0_events,
    input wire logic [IOD_DW-1:0] timer1_events,
    input wire logic rvalid,
    input wire logic skip,
    input wire logic ext_read,
    input wire logic [IOD_MAW-1:0] ext_addr,
    input wire logic [IOD_DW-1:0] port_b_drive,
    input wire logic [IOD_DW-1:0] port_b_enable,
    input wire logic [IOD_DW-1:0] timer0_flags
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Hardware set wins over a clear, so flag checks only hold while no event arrives.
    logic quiet;
    assign quiet = ce && timer0_events == 8'h00 && timer1_events == 8'h00;
    sequence s_ext_req;
        ce && op == IOD_OP_MEM_READ && mem_addr >= IOD_EXT_FIRST;
    endsequence
    sequence s_ext_ans;
        ext_read && rvalid && ext_addr == $past(mem_addr);
    endsequence
    a_ext_read_fwd: assert property (s_ext_req |=> s_ext_ans)
        else $error("extended read not forwarded");
    a_low_mem_refused: assert property (ce && op == IOD_OP_MEM_READ && mem_addr < 8'h20 |=> !rvalid)
        else $error("low data address answered");
    a_bit_range_hold: assert property (quiet && op inside {IOD_OP_BIT_RAISE, IOD_OP_BIT_LOWER}
        && io_addr > IOD_BIT_SPACE_LAST |=> $stable({port_b_drive, port_b_enable, timer0_flags}))
        else $error("bit op outside low range changed state");
    a_skip_only_test: assert property (ce && (op != IOD_OP_BIT_TEST || io_addr > IOD_BIT_SPACE_LAST) |=> !skip)
        else $error("skip without a valid bit test");
    a_mem_write_map: assert property (ce && op == IOD_OP_MEM_WRITE && mem_addr == 8'h25
        |=> port_b_drive == $past(wdata))
        else $error("data write not mapped to offset");
    a_flag_zero_keep: assert property (quiet && op == IOD_OP_IO_WRITE && io_addr == 6'h15 && wdata == 8'h00
        |=> $stable(timer0_flags))
        else $error("zero write changed flags");
    a_flag_one_clear: assert property (quiet && op == IOD_OP_IO_WRITE && io_addr == 6'h15
        |=> (timer0_flags & $past(wdata)) == 8'h00)
        else $error("one write left a flag set");
    a_raise_one_bit: assert property (ce && op == IOD_OP_BIT_RAISE && io_addr == 6'h05
        |=> port_b_drive == ($past(port_b_drive) | (8'h01 << $past(bit_sel))))
        else $error("bit raise touched other bits");
endmodule
bind iod_top iod_monitor i_iod_monitor (.clk(clk), .rst(rst), .ce(ce), .op(op), .io_addr(io_addr),
    .mem_addr(mem_addr), .bit_sel(bit_sel), .wdata(wdata), .timer0_events(timer0_events),
    .timer1_events(timer1_events), .rvalid(rvalid), .skip(skip), .ext_read(ext_read), .ext_addr(ext_addr),
    .port_b_drive(port_b_drive), .port_b_enable(port_b_enable), .timer0_flags(timer0_flags));

// ---- verification/iod_core_model.sv ----
// Model of the core issuing one decoded access at a time.
// Assumes calls start just after a rising edge; the answer stands after return.
`timescale 1ns/1ps
module iod_core_model
    import iod_pkg::*;
(
    input wire logic clk,
    output iod_op_t op,
    output logic [IOD_IOAW-1:0] io_addr,
    output logic [IOD_MAW-1:0] mem_addr,
    output logic [IOD_BITW-1:0] bit_sel,
    output logic [IOD_DW-1:0] wdata
);
    initial op = IOD_OP_NONE;
    initial {io_addr, mem_addr, bit_sel, wdata} = '0;
    task automatic issue(input iod_op_t o, input logic [IOD_IOAW-1:0] a, input logic [IOD_MAW-1:0] m,
        input logic [IOD_BITW-1:0] b, input logic [IOD_DW-1:0] d);
        // One idle edge first, so back-to-back calls never drive two values in one time step.
        @(posedge clk);
        #1;
        op = o;
        {io_addr, mem_addr, bit_sel, wdata} = {a, m, b, d};
        @(posedge clk);
        #1;
        // Idle operands show their inverse so a design that latches late is caught.
        op = IOD_OP_NONE;
        {io_addr, mem_addr, bit_sel, wdata} = {~a, ~m, ~b, ~d};
    endtask
endmodule

// ---- verification/test_iod_top.sv ----
// Self-checking bench for the low I/O space decoder.
// Assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module test_iod_top;
    import iod_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [IOD_DW-1:0] pin_a = 8'hf6;
    logic [IOD_DW-1:0] pin_b = 8'h04;
    logic [IOD_DW-1:0] pin_c = 8'h5e;
    logic [IOD_DW-1:0] pin_d = 8'ha7;
    logic [IOD_DW-1:0] ev0 = 8'h00;
    logic [IOD_DW-1:0] ev1 = 8'h00;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    iod_op_t op;
    logic [IOD_IOAW-1:0] io_addr;
    logic [IOD_MAW-1:0] mem_addr, ext_addr;
    logic [IOD_BITW-1:0] bit_sel;
    logic [IOD_DW-1:0] wdata, rdata, pbd, pbe, tf0;
    logic [IOD_DW-1:0] pad, pae, pcd, pce, pdd, pde, pbc, tf1, ewd;
    logic rvalid, skip, ext_read, ext_write;
    always #10 clk = ~clk;
    iod_core_model i_iod_core_model (.clk(clk), .op(op), .io_addr(io_addr), .mem_addr(mem_addr),
        .bit_sel(bit_sel), .wdata(wdata));
    iod_top i_iod_top (.clk(clk), .rst(rst), .ce(ce), .op(op), .io_addr(io_addr), .mem_addr(mem_addr),
        .bit_sel(bit_sel), .wdata(wdata), .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c), .pin_d(pin_d),
        .timer0_events(ev0), .timer1_events(ev1), .rdata(rdata), .rvalid(rvalid), .skip(skip),
        .ext_read(ext_read), .ext_write(ext_write), .ext_addr(ext_addr), .ext_wdata(ewd),
        .port_a_drive(pad), .port_a_enable(pae), .port_b_drive(pbd), .port_b_enable(pbe), .port_c_drive(pcd),
        .port_c_enable(pce), .port_d_drive(pdd), .port_d_enable(pde), .pullup_break_ctrl(pbc),
        .timer0_flags(tf0), .timer1_flags(tf1));
    task automatic go(input iod_op_t o, input logic [IOD_IOAW-1:0] a, input logic [IOD_MAW-1:0] m,
        input logic [IOD_BITW-1:0] b, input logic [IOD_DW-1:0] d);
        i_iod_core_model.issue(o, a, m, b, d);
    endtask
    task automatic chk8(input logic [IOD_DW-1:0] got, input logic [IOD_DW-1:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        chk8({7'h00, got}, {7'h00, exp}, what);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Each call takes two cycles, so the sequence needs about eighty; a thousand only trips on a hang.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        chk8(pbd, 8'h00, "reset drive");
        go(IOD_OP_MEM_WRITE, 6'h00, 8'h25, 3'h0, 8'h5a);
        chk8(pbd, 8'h5a, "data write map");
        go(IOD_OP_IO_WRITE, 6'h04, 8'h00, 3'h0, 8'hc3);
        go(IOD_OP_MEM_READ, 6'h00, 8'h24, 3'h0, 8'h00);
        chk8(rdata, 8'hc3, "data read map");
        go(IOD_OP_IO_READ, 6'h05, 8'h00, 3'h0, 8'h00);
        chk8(rdata, 8'h5a, "short read");
        go(IOD_OP_MEM_READ, 6'h00, 8'h10, 3'h0, 8'h00);
        chk1(rvalid, 1'b0, "low data refused");
        go(IOD_OP_IO_WRITE, 6'h0d, 8'h00, 3'h0, 8'hff);
        chk8(pae, 8'h0f, "port a direction");
        go(IOD_OP_MEM_WRITE, 6'h00, 8'h2e, 3'h0, 8'ha5);
        chk8(pad, 8'h05, "port a output");
        go(IOD_OP_IO_WRITE, 6'h07, 8'h00, 3'h0, 8'h3c);
        chk8(pce, 8'h3c, "port c direction");
        go(IOD_OP_MEM_WRITE, 6'h00, 8'h28, 3'h0, 8'h96);
        chk8(pcd, 8'h96, "port c output");
        go(IOD_OP_IO_WRITE, 6'h0a, 8'h00, 3'h0, 8'h81);
        chk8(pde, 8'h81, "port d direction");
        go(IOD_OP_IO_WRITE, 6'h0b, 8'h00, 3'h0, 8'h18);
        chk8(pdd, 8'h18, "port d output");
        go(IOD_OP_MEM_WRITE, 6'h00, 8'h32, 3'h0, 8'h6b);
        chk8(pbc, 8'h6b, "pull-up control");
        go(IOD_OP_IO_READ, 6'h0c, 8'h00, 3'h0, 8'h00);
        chk8(rdata, 8'h06, "port a pins");
        go(IOD_OP_MEM_READ, 6'h00, 8'h26, 3'h0, 8'h00);
        chk8(rdata, 8'h5e, "port c pins");
        go(IOD_OP_IO_READ, 6'h09, 8'h00, 3'h0, 8'h00);
        chk8(rdata, 8'ha7, "port d pins");
        ce = 1'b0;
        go(IOD_OP_IO_WRITE, 6'h05, 8'h00, 3'h0, 8'hff);
        chk8(pbd, 8'h5a, "frozen by enable");
        ce = 1'b1;
        $display("test map done");
        go(IOD_OP_BIT_RAISE, 6'h05, 8'h00, 3'h0, 8'h00);
        chk8(pbd, 8'h5b, "bit raise");
        go(IOD_OP_BIT_LOWER, 6'h05, 8'h00, 3'h6, 8'h00);
        chk8(pbd, 8'h1b, "bit lower");
        go(IOD_OP_BIT_RAISE, 6'h25, 8'h00, 3'h7, 8'h00);
        chk8(pbd, 8'h1b, "raise out of range");
        go(IOD_OP_BIT_LOWER, 6'h24, 8'h00, 3'h0, 8'h00);
        chk8(pbe, 8'hc3, "lower out of range");
        for (int i = 0; i < 4; i++) begin
            go(IOD_OP_BIT_TEST, 6'h03, 8'h00, i[1] ? 3'h3 : 3'h2, {7'h00, i[0]});
            chk1(skip, pin_b[i[1] ? 3 : 2] == i[0], "bit test skip");
        end
        go(IOD_OP_BIT_TEST, 6'h23, 8'h00, 3'h0, 8'h00);
        chk1(skip, 1'b0, "bit test out of range");
        $display("test bit done");
        ev0 = 8'h07;
        ev1 = 8'hff;
        @(posedge clk);
        #1 ev0 = 8'h00;
        ev1 = 8'h00;
        chk8(tf0, 8'h07, "flags set");
        chk8(tf1, 8'h27, "timer1 flags set");
        go(IOD_OP_IO_WRITE, 6'h15, 8'h00, 3'h0, 8'h00);
        chk8(tf0, 8'h07, "zero write keeps");
        go(IOD_OP_IO_WRITE, 6'h15, 8'h00, 3'h0, 8'h02);
        chk8(tf0, 8'h05, "one write clears");
        go(IOD_OP_BIT_RAISE, 6'h15, 8'h00, 3'h0, 8'h00);
        chk8(tf0, 8'h04, "raise clears one flag");
        go(IOD_OP_BIT_LOWER, 6'h15, 8'h00, 3'h2, 8'h00);
        chk8(tf0, 8'h04, "lower keeps flag");
        go(IOD_OP_MEM_WRITE, 6'h00, 8'h36, 3'h0, 8'h21);
        chk8(tf1, 8'h06, "timer1 one write clears");
        $display("test flags done");
        go(IOD_OP_MEM_READ, 6'h00, 8'h80, 3'h0, 8'h00);
        chk8({ext_read, rvalid, 6'h00}, 8'hc0, "extended read");
        chk8(ext_addr, 8'h80, "extended address");
        go(IOD_OP_MEM_WRITE, 6'h00, 8'hff, 3'h0, 8'ha5);
        chk1(ext_write, 1'b1, "extended write");
        chk8(ewd, 8'ha5, "extended write data");
        go(IOD_OP_IO_READ, 6'h3f, 8'h00, 3'h0, 8'h00);
        chk8({ext_read, rvalid, 6'h00}, 8'h40, "short read stays local");
        chk8(rdata, 8'h00, "top short address");
        go(IOD_OP_IO_WRITE, 6'h00, 8'h00, 3'h0, 8'hff);
        go(IOD_OP_IO_READ, 6'h00, 8'h00, 3'h0, 8'h00);
        chk8(rdata, 8'h00, "reserved reads zero");
        $display("test ext done");
        tally_and_finish();
    end
endmodule
